// ---- src/orc_relay_ctrl.sv ----
// Overview of operation
// [RULE1] Eight-bit shift register, bit n drives output n+1
// [RULE2] Shift data in on rising link clock
// [RULE3] Chip select rising edge copies shift register out
// [RULE4] Data out shows last stage, falling edges
// [RULE5] Most significant bit enters and leaves first
// [RULE6] Outputs hold while shifting
// [RULE7] Deselected: ignore link, data out shows first bit
// [RULE8] Host raises select after eight bits
// [RULE9] Only last eight bits are kept
// [RULE10] Select bits binary, value n picks output n+1
// [RULE11] Level high turns on, low turns off
// [RULE12] Deselected: select and level have no effect
// [RULE13] Select rising edge updates only addressed output
// [RULE14] Address taken when select falls
// [RULE15] Set-all forces every latch and register on
// [RULE16] Clear-all forces everything off, beats set-all
// [RULE17] Outputs are open-drain sinks, on means pulled
// [RULE18] Pins synchronised, edges found on system clock
// [RULE19] Reset leaves registers and latch cleared
module orc_relay_ctrl
  import orc_pkg::*;
#(
  parameter int FIFO_DEPTH = ORC_FIFO_DEPTH
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic din_in,
  input wire logic set_n_in,
  input wire logic clear_n_in,
  input wire logic switch_level_in,
  input wire logic sel_bit0_in,
  input wire logic sel_bit1_in,
  input wire logic sel_bit2_in,
  input wire logic mode_parallel_in,
  input wire logic apply_en_in,
  input wire logic [7:0] relay_pin_in,
  output logic dout_out,
  output logic [7:0] relay_drive_out,
  output logic [7:0] relay_oe_out,
  output logic [7:0] relay_sense_out,
  output logic [7:0] latch_state_out,
  output logic upd_ready_out,
  output logic upd_pending_out
);

  // ****************************************
  // Pin synchronisers
  // ****************************************
  logic [ORC_SYNC_W-1:0] pins_w;
  logic [ORC_SYNC_W-1:0] sync_w;

  assign pins_w = {relay_pin_in, mode_parallel_in, sel_bit2_in, sel_bit1_in,
                   sel_bit0_in, switch_level_in, clear_n_in, set_n_in, din_in,
                   cs_n_in, sclk_in};

  orc_sync #(
    .W(ORC_SYNC_W),
    .RST(ORC_SYNC_RST)
  ) u_sync (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .async_in(pins_w),
    .sync_out(sync_w)
  ); // [RULE18]

  wire sclk_w = sync_w[ORC_IX_SCLK];
  wire cs_n_w = sync_w[ORC_IX_CS_N];
  wire din_w = sync_w[ORC_IX_DIN];
  wire set_n_w = sync_w[ORC_IX_SET_N];
  wire clr_n_w = sync_w[ORC_IX_CLR_N];
  wire level_w = sync_w[ORC_IX_LEVEL];
  wire [ORC_ADDR_W-1:0] sel_w = sync_w[ORC_IX_SEL +: ORC_ADDR_W];
  wire par_w = sync_w[ORC_IX_MODE];
  wire [7:0] pin_w = sync_w[ORC_IX_PIN +: ORC_CH];

  // ****************************************
  // Edge detection
  // ****************************************
  // The link clock must be several times slower than the system
  // clock, or edges are missed
  logic sclk_prev_q;
  logic cs_n_prev_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      sclk_prev_q <= 1'b0;
      cs_n_prev_q <= 1'b1;
    end
    else
    begin
      sclk_prev_q <= sclk_w;
      cs_n_prev_q <= cs_n_w;
    end
  end

  wire sclk_rise_w = sclk_w && !sclk_prev_q; // [RULE18]
  wire sclk_fall_w = !sclk_w && sclk_prev_q; // [RULE18]
  wire cs_rise_w = cs_n_w && !cs_n_prev_q; // [RULE18]
  wire cs_fall_w = !cs_n_w && cs_n_prev_q; // [RULE18]
  wire selected_w = !cs_n_w && !cs_n_prev_q;

  // ****************************************
  // Global set and clear
  // ****************************************
  wire force_clr_w = !clr_n_w; // [RULE16]
  wire force_set_w = !set_n_w && clr_n_w; // [RULE15] [RULE16]
  wire force_w = force_clr_w || force_set_w;

  // ****************************************
  // Serial shift register
  // ****************************************
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic dout_q;
  logic dout_d;

  // Shifting only while selected; a deselected link is ignored
  wire shift_en_w = selected_w && sclk_rise_w && !par_w; // [RULE2] [RULE7]

  always_comb
  begin
    shift_d = shift_q;
    if (force_clr_w)
      shift_d = ORC_ALL_OFF; // [RULE16]
    else if (force_set_w)
      shift_d = ORC_ALL_ON; // [RULE15]
    else if (shift_en_w)
      shift_d = {shift_q[6:0], din_w}; // [RULE1] [RULE5] [RULE9]
  end

  // Data out follows the last stage on falling edges, and again at
  // deselection so that the first bit in is what stays visible
  always_comb
  begin
    dout_d = dout_q;
    if (force_clr_w)
      dout_d = 1'b0; // [RULE16]
    else if (force_set_w)
      dout_d = 1'b1; // [RULE15]
    else if (selected_w && sclk_fall_w && !par_w)
      dout_d = shift_q[7]; // [RULE4] [RULE5]
    else if (cs_rise_w && !par_w)
      dout_d = shift_q[7]; // [RULE7]
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      shift_q <= ORC_LATCH_RST; // [RULE19]
      dout_q <= 1'b0;
    end
    else
    begin
      shift_q <= shift_d;
      dout_q <= dout_d;
    end
  end

  // ****************************************
  // Parallel address capture
  // ****************************************
  // Address is frozen when select falls; later changes are ignored
  logic [ORC_ADDR_W-1:0] addr_q;

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      addr_q <= '0;
    else if (cs_fall_w)
      addr_q <= sel_w; // [RULE14]
  end

  // ****************************************
  // Link state machine
  // ****************************************
  orc_link_e state_q;
  orc_link_e state_d;
  orc_upd_s upd_q;
  orc_upd_s upd_d;
  orc_upd_s head_w;
  logic fifo_wr_ready_w;
  logic fifo_rd_valid_w;

  // A new deselect edge arriving while a word still waits for room
  // is lost; the ready output lets the host pace itself
  wire push_w = (state_q == ORC_LINK_PUSH);
  wire push_done_w = push_w && fifo_wr_ready_w;

  always_comb
  begin
    upd_d = upd_q;
    if (cs_rise_w && !push_w)
    begin
      upd_d.par = par_w;
      upd_d.addr = addr_q; // [RULE13] [RULE14]
      upd_d.level = level_w; // [RULE11]
      upd_d.data = shift_q; // [RULE3] [RULE9]
    end
  end

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      ORC_LINK_IDLE:
      begin
        if (cs_fall_w)
          state_d = ORC_LINK_SEL;
      end
      ORC_LINK_SEL:
      begin
        if (cs_rise_w)
          state_d = ORC_LINK_PUSH; // [RULE3] [RULE13]
      end
      ORC_LINK_PUSH:
      begin
        if (push_done_w)
          state_d = cs_n_w ? ORC_LINK_IDLE : ORC_LINK_SEL;
      end
      default:
        state_d = ORC_LINK_IDLE;
    endcase
    // Set and clear abandon any word in flight
    if (force_w)
      state_d = cs_n_w ? ORC_LINK_IDLE : ORC_LINK_SEL;
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      state_q <= ORC_LINK_IDLE;
      upd_q <= '0;
    end
    else
    begin
      state_q <= state_d;
      upd_q <= upd_d;
    end
  end

  // ****************************************
  // Update queue
  // ****************************************
  logic [$bits(orc_upd_s)-1:0] head_bits_w;
  // Set and clear flush the queue: queued work is traded for a clean restart
  wire fifo_wr_w = push_w && !force_w;
  wire fifo_rd_w = apply_en_in && !force_w;
  wire pop_w = fifo_rd_valid_w && fifo_rd_w;

  orc_fifo #(
    .WIDTH($bits(orc_upd_s)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .ref_clk_in(ref_clk_in),
    .nrst_in(nrst_in),
    .flush_in(force_w),
    .wr_valid_in(fifo_wr_w),
    .wr_ready_out(fifo_wr_ready_w),
    .wr_data_in(upd_q),
    .rd_valid_out(fifo_rd_valid_w),
    .rd_ready_in(fifo_rd_w),
    .rd_data_out(head_bits_w)
  );

  assign head_w = orc_upd_s'(head_bits_w);

  // ****************************************
  // Output latch
  // ****************************************
  // Latch only moves on a queued update or on set and clear; shifting never writes it, though a queued update can pop mid-shift
  logic [7:0] latch_q;
  logic [7:0] latch_d;
  logic [7:0] onehot_w;

  assign onehot_w = 8'h01 << head_w.addr; // [RULE10]

  always_comb
  begin
    latch_d = latch_q; // [RULE6] [RULE12]
    if (force_clr_w)
      latch_d = ORC_ALL_OFF; // [RULE16]
    else if (force_set_w)
      latch_d = ORC_ALL_ON; // [RULE15]
    else if (pop_w && head_w.par)
    begin
      if (head_w.level)
        latch_d = latch_q | onehot_w; // [RULE11] [RULE13]
      else
        latch_d = latch_q & ~onehot_w; // [RULE11] [RULE13]
    end
    else if (pop_w)
      latch_d = head_w.data; // [RULE1] [RULE3]
  end

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
      latch_q <= ORC_LATCH_RST; // [RULE19]
    else
      latch_q <= latch_d;
  end

  // ****************************************
  // Output registers
  // ****************************************
  // Enable is registered from the next latch value, so the two agree
  // Drive stays low: an off channel is released, never pushed high
  // Sense lags the pins by the synchroniser depth plus the output register
  // Ready drops while a word waits for room, so a paced host loses nothing
  wire ready_w = fifo_wr_ready_w && !push_w;
  wire pending_w = fifo_rd_valid_w || push_w;

  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in)
    begin
      relay_drive_out <= ORC_DRIVE_LEVEL;
      relay_oe_out <= ORC_LATCH_RST; // [RULE19]
      relay_sense_out <= '0;
      latch_state_out <= ORC_LATCH_RST;
      dout_out <= 1'b0;
      upd_ready_out <= 1'b0;
      upd_pending_out <= 1'b0;
    end
    else
    begin
      relay_drive_out <= ORC_DRIVE_LEVEL; // [RULE17]
      relay_oe_out <= latch_d; // [RULE17]
      relay_sense_out <= pin_w;
      latch_state_out <= latch_d;
      dout_out <= dout_d; // [RULE4]
      upd_ready_out <= ready_w;
      upd_pending_out <= pending_w;
    end
  end

endmodule : orc_relay_ctrl

// ---- src/orc_pkg.sv ----
package orc_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int ORC_CH = 8;
  localparam int ORC_ADDR_W = 3;
  localparam int ORC_FIFO_DEPTH = 8;
  localparam int ORC_SYNC_W = 18;

  // ****************************************
  // Reset and force values
  // ****************************************
  localparam logic [7:0] ORC_LATCH_RST = 8'h00;
  localparam logic [7:0] ORC_ALL_ON = 8'hFF;
  localparam logic [7:0] ORC_ALL_OFF = 8'h00;
  localparam logic [7:0] ORC_DRIVE_LEVEL = 8'h00;
  // Idle level of the synchronised pins: chip select, set and clear high
  localparam logic [17:0] ORC_SYNC_RST = 18'h0001A;

  // ****************************************
  // Positions in the synchronised pin vector
  // ****************************************
  localparam int ORC_IX_SCLK = 0;
  localparam int ORC_IX_CS_N = 1;
  localparam int ORC_IX_DIN = 2;
  localparam int ORC_IX_SET_N = 3;
  localparam int ORC_IX_CLR_N = 4;
  localparam int ORC_IX_LEVEL = 5;
  localparam int ORC_IX_SEL = 6;
  localparam int ORC_IX_MODE = 9;
  localparam int ORC_IX_PIN = 10;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    ORC_LINK_IDLE = 2'b00,
    ORC_LINK_SEL = 2'b01,
    ORC_LINK_PUSH = 2'b11
  } orc_link_e;

  typedef struct packed {
    logic par;
    logic [2:0] addr;
    logic level;
    logic [7:0] data;
  } orc_upd_s;

endpackage : orc_pkg

// ---- src/orc_sync.sv ----
module orc_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST = '0
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);

  // ****************************************
  // Two-stage synchroniser per bit
  // ****************************************
  // Stage one feeds stage two only, to keep metastability contained
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic meta_q;
      always_ff @(posedge ref_clk_in)
      begin
        if (!nrst_in)
        begin
          meta_q <= RST[i];
          sync_out[i] <= RST[i];
        end
        else
        begin
          meta_q <= async_in[i];
          sync_out[i] <= meta_q;
        end
      end
    end
  endgenerate

endmodule : orc_sync

// ---- src/orc_fifo.sv ----
module orc_fifo #(
  parameter int WIDTH = 13,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic flush_in,
  input wire logic wr_valid_in,
  output logic wr_ready_out,
  input wire logic [WIDTH-1:0] wr_data_in,
  output logic rd_valid_out,
  input wire logic rd_ready_in,
  output logic [WIDTH-1:0] rd_data_out
);

  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int CW = $clog2(DEPTH + 1);

  // ****************************************
  // Storage and pointers
  // ****************************************
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] wr_ptr_q;
  logic [AW-1:0] rd_ptr_q;
  logic [CW-1:0] count_q;

  wire full_w = (count_q == CW'(DEPTH));
  wire empty_w = (count_q == '0);
  wire push_w = wr_valid_in && !full_w;
  wire pop_w = rd_ready_in && !empty_w;
  wire [AW-1:0] wr_nxt_w = (wr_ptr_q == AW'(DEPTH - 1)) ? '0 : wr_ptr_q + 1'b1;
  wire [AW-1:0] rd_nxt_w = (rd_ptr_q == AW'(DEPTH - 1)) ? '0 : rd_ptr_q + 1'b1;

  assign wr_ready_out = !full_w;
  assign rd_valid_out = !empty_w;
  assign rd_data_out = mem_q[rd_ptr_q];

  always_ff @(posedge ref_clk_in)
  begin
    if (push_w)
      mem_q[wr_ptr_q] <= wr_data_in;
  end

  // Flush drops every pending entry in one cycle
  always_ff @(posedge ref_clk_in)
  begin
    if (!nrst_in || flush_in)
    begin
      wr_ptr_q <= '0;
      rd_ptr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (push_w)
        wr_ptr_q <= wr_nxt_w;
      if (pop_w)
        rd_ptr_q <= rd_nxt_w;
      if (push_w && !pop_w)
        count_q <= count_q + 1'b1;
      else if (pop_w && !push_w)
        count_q <= count_q - 1'b1;
    end
  end

endmodule : orc_fifo

// ---- test/orc_relay_ctrl_assertions.sv ----
module orc_chk
  import orc_pkg::*;
(
  input wire logic ref_clk_in,
  input wire logic nrst_in,
  input wire logic cs_n_in,
  input wire logic set_n_in,
  input wire logic clear_n_in,
  input wire logic mode_parallel_in,
  input wire logic dout_out,
  input wire logic [7:0] relay_drive_out,
  input wire logic [7:0] relay_oe_out,
  input wire logic [7:0] latch_state_out,
  input wire logic upd_pending_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic quiet;
  logic idle;
  assign quiet = set_n_in && clear_n_in;
  // Pending covers the queue, so a late update never reads as a stray change
  assign idle = quiet && !upd_pending_out;
  default clocking @(posedge ref_clk_in);
  endclocking
  default disable iff (!nrst_in);
  property p_reset; $rose(nrst_in) |-> relay_oe_out == ORC_LATCH_RST && !dout_out; endproperty
  a_reset: assert property (p_reset) else $error("outputs not clear after reset");
  property p_sink; relay_drive_out == ORC_DRIVE_LEVEL && relay_oe_out == latch_state_out; endproperty
  a_sink: assert property (p_sink) else $error("open drain drive wrong");
  property p_clear; (!clear_n_in)[*6] |-> relay_oe_out == ORC_ALL_OFF && !dout_out; endproperty
  a_clear: assert property (p_clear) else $error("clear all not applied");
  property p_set; (!set_n_in && clear_n_in)[*6] |-> relay_oe_out == ORC_ALL_ON && dout_out; endproperty
  a_set: assert property (p_set) else $error("set all not applied");
  property p_desel; (cs_n_in && idle)[*8] |=> $stable(relay_oe_out); endproperty
  a_desel: assert property (p_desel) else $error("output moved while deselected");
  property p_shift; (!cs_n_in && idle)[*8] |=> $stable(relay_oe_out); endproperty
  a_shift: assert property (p_shift) else $error("output moved while selected");
  property p_dout; (cs_n_in && quiet)[*8] |=> $stable(dout_out); endproperty
  a_dout: assert property (p_dout) else $error("serial out moved while deselected");
  property p_one;
    (mode_parallel_in && quiet)[*6] |=> $countones(relay_oe_out ^ $past(relay_oe_out)) <= 1;
  endproperty
  a_one: assert property (p_one) else $error("parallel update hit several outputs");
  c_serial: cover property (!mode_parallel_in && $rose(cs_n_in));
  c_par: cover property (mode_parallel_in && $changed(relay_oe_out));
  c_both: cover property (!clear_n_in && !set_n_in);
endmodule : orc_chk

bind orc_relay_ctrl orc_chk u_chk (.*);

// ---- test/orc_host_model.sv ----
module orc_host_model
  import orc_pkg::*;
(
  input wire logic ref_clk_in,
  output logic sclk_out,
  output logic cs_n_out,
  output logic din_out,
  output logic [ORC_ADDR_W-1:0] sel_out,
  output logic level_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial
  begin
    sclk_out = 1'h0;
    cs_n_out = 1'h1;
    din_out = 1'h0;
    sel_out = 3'h0;
    level_out = 1'h0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask : tick
  // Link clock 320 ns, rests low between frames
  task automatic put_bit(input logic b);
    din_out = b;
    tick(4);
    sclk_out = 1'h1;
    tick(2);
    din_out = ~b; // Hold over: inverse, so a late sample cannot pass
    tick(2);
    sclk_out = 1'h0;
  endtask : put_bit
  task automatic select();
    cs_n_out = 1'h0;
    tick(4);
  endtask : select
  task automatic deselect();
    tick(4);
    cs_n_out = 1'h1;
    tick(4);
  endtask : deselect
  task automatic par_write(input logic [2:0] a, input logic lvl, input logic late);
    sel_out = a;
    tick(4);
    cs_n_out = 1'h0;
    tick(4);
    level_out = lvl;
    if (late)
      sel_out = ~a;
    tick(4);
    cs_n_out = 1'h1;
    tick(2);
    sel_out = ~a;
    level_out = ~lvl;
    tick(2);
  endtask : par_write
endmodule : orc_host_model

// ---- test/tb_top.sv ----
module tb_top
  import orc_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic ref_clk_in, nrst_in, set_n_in, clear_n_in, mode_parallel_in, apply_en_in, l;
  logic dout_out, upd_ready_out, upd_pending_out;
  wire logic sclk_in, cs_n_in, din_in, switch_level_in, sel_bit0_in, sel_bit1_in, sel_bit2_in;
  logic [7:0] relay_pin_in, relay_drive_out, relay_oe_out, relay_sense_out, latch_state_out;
  logic [7:0] w, prev, exp, seed;
  logic [11:0] lw;
  int fail_count, check_count, i, j;
  assign relay_pin_in = ~relay_oe_out; // Pull-up: a sinking output reads low
  orc_relay_ctrl DUT (.*);
  orc_host_model host (.ref_clk_in(ref_clk_in), .sclk_out(sclk_in), .cs_n_out(cs_n_in),
    .din_out(din_in), .sel_out({sel_bit2_in, sel_bit1_in, sel_bit0_in}),
    .level_out(switch_level_in));
  function automatic logic [7:0] lfsr(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr
  function automatic logic [7:0] put(input logic [7:0] c, input logic [2:0] a, input logic v);
    logic [7:0] r;
    r = c;
    r[a] = v;
    return r;
  endfunction : put
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_in);
    #2;
  endtask : tick
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] want);
    check_count++;
    if (seen !== want)
    begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, want, seen);
    end
  endtask : check
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : conclude
  task automatic do_reset(input logic m);
    nrst_in = 1'h0;
    mode_parallel_in = m;
    tick(20);
    nrst_in = 1'h1;
    tick(3);
  endtask : do_reset
  initial
  begin
    ref_clk_in = 1'h0;
    forever #20 ref_clk_in = ~ref_clk_in;
  end
  initial
  begin
    repeat (90000) @(posedge ref_clk_in);
    fail_count++;
    conclude();
  end
  initial
  begin
    set_n_in = 1'h1;
    clear_n_in = 1'h1;
    apply_en_in = 1'h1;
    do_reset(1'h0);
    check("reset latch", latch_state_out, ORC_LATCH_RST);
    seed = 8'h3A;
    prev = 8'h00;
    for (i = 0; i < 10; i++)
    begin
      w = (i == 0) ? 8'h80 : (i == 1) ? 8'h01 : seed;
      seed = lfsr(seed);
      if (i == 3)
        host.put_bit(1'h1); // Stray link clock while deselected
      host.select();
      host.put_bit(w[7]);
      tick(6);
      check("dout delayed", {7'h00, dout_out}, {7'h00, prev[6]});
      check("latch while shifting", latch_state_out, prev);
      for (j = 6; j >= 0; j--)
        host.put_bit(w[j]);
      host.deselect();
      tick(10);
      check("serial latch", latch_state_out, w);
      check("dout deselected", {7'h00, dout_out}, {7'h00, w[7]});
      check("pin readback", relay_sense_out, ~w);
      prev = w;
    end
    lw = {4'h9, seed};
    host.select();
    for (j = 11; j >= 0; j--)
      host.put_bit(lw[j]);
    host.deselect();
    tick(10);
    check("long word", latch_state_out, lw[7:0]);
    host.select();
    for (j = 2; j >= 0; j--)
      host.put_bit(lw[j]);
    host.deselect();
    tick(10);
    check("short word", latch_state_out, {lw[4:0], lw[2:0]});
    $display("serial tests done");
    set_n_in = 1'h0;
    tick(8);
    check("set all", latch_state_out, ORC_ALL_ON);
    check("sinks on", relay_oe_out, ORC_ALL_ON);
    check("drive level", relay_drive_out, ORC_DRIVE_LEVEL);
    clear_n_in = 1'h0;
    tick(8);
    check("clear wins", latch_state_out, ORC_ALL_OFF);
    set_n_in = 1'h1;
    clear_n_in = 1'h1;
    tick(8);
    check("after release", latch_state_out, ORC_ALL_OFF);
    $display("set and clear done");
    do_reset(1'h1);
    exp = 8'h00;
    for (i = 0; i < 16; i++)
    begin
      l = (i < 8) ? 1'h1 : seed[0];
      seed = lfsr(seed);
      host.par_write(i[2:0], l, i == 5 || i == 12);
      exp = put(exp, i[2:0], l);
      tick(10);
      check("par latch", latch_state_out, exp);
    end
    $display("parallel tests done");
    apply_en_in = 1'h0;
    for (i = 0; i < 8; i++)
      host.par_write(i[2:0], ~exp[i], 1'h0);
    check("queue full", {7'h00, upd_ready_out}, 8'h00);
    check("stalled latch", latch_state_out, exp);
    apply_en_in = 1'h1;
    for (j = 0; j < 60 && upd_pending_out !== 1'h0; j++)
      tick(1);
    if (upd_pending_out !== 1'h0)
    begin
      fail_count++;
      conclude();
    end
    tick(3);
    check("drained latch", latch_state_out, ~exp);
    check("ready again", {7'h00, upd_ready_out}, 8'h01);
    $display("queue test done");
    conclude();
  end
endmodule : tb_top
